// >>> anbpa_defs.svh
// Offsets, field positions, reset values and counts of the base page advertisement bank
`ifndef ANBPA_DEFS_SVH
`define ANBPA_DEFS_SVH

// ==========================================================
// Management addressing
`define ANBPA_DEV_AN        5'h07
`define ANBPA_OFF_LOW       16'h0010
`define ANBPA_OFF_MID       16'h0011
`define ANBPA_OFF_HIGH      16'h0012

// ==========================================================
// Reset values, write mask and random source taps
`define ANBPA_RST_LOW       16'h1001
`define ANBPA_RST_MID       16'h0080
`define ANBPA_RST_HIGH      16'h4000
`define ANBPA_LOW_WMASK     16'hBFFF
`define ANBPA_LFSR_SEED     16'hACE1
`define ANBPA_LFSR_TAPS     16'hB400

// ==========================================================
// Fields of the low word (same positions as codeword D15..D0)
`define ANBPA_NP_BIT        15
`define ANBPA_ACK_BIT       14
`define ANBPA_RF_BIT        13
`define ANBPA_PAUSE_MSB     12
`define ANBPA_PAUSE_LSB     10
`define ANBPA_ECHO_MSB      9
`define ANBPA_ECHO_LSB      5
`define ANBPA_SEL_MSB       4
`define ANBPA_SEL_LSB       0

// ==========================================================
// Codeword positions of the mid and high words
`define ANBPA_CW_MID_MSB    31
`define ANBPA_CW_MID_LSB    21
`define ANBPA_MID_MSB       15
`define ANBPA_MID_LSB       5
`define ANBPA_CW_TOK_MSB    20
`define ANBPA_CW_TOK_LSB    16
`define ANBPA_CW_HIGH_MSB   47
`define ANBPA_CW_HIGH_LSB   32

// ==========================================================
// Serial frame counts
`define ANBPA_PRE_ONES      6'd32
`define ANBPA_HDR_LAST      6'd12
`define ANBPA_DATA_LAST     6'd15

`endif

// >>> anbpa_lp_model.sv
// Link partner model feeding the negotiation inputs of the advertisement bank
module anbpa_lp_model
#(
   parameter logic [4:0] LP_TOKEN = 5'h16
) (
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic       go_i,
   input  wire logic       ack_i,
   input  wire logic       exch_i,
   output logic            an_start_o,
   output logic            ack_o,
   output logic            nonce_match_o,
   output logic [4:0]      lp_token_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Page start, acknowledge and nonce exchange, one cycle late
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         an_start_o    <= 1'b0;
         ack_o         <= 1'b0;
         nonce_match_o <= 1'b0;
         lp_token_o    <= 5'h00;
      end else begin
         an_start_o    <= go_i;
         ack_o         <= ack_i;
         nonce_match_o <= exch_i;
         // Token is junk until exchanged, so it churns every cycle
         lp_token_o    <= exch_i ? LP_TOKEN : ~lp_token_o;
      end
   end
endmodule // anbpa_lp_model

// >>> anbpa_pkg.sv
// Types of the base page advertisement bank
package anbpa_pkg;

   // ==========================================================
   // Serial frame states
   typedef enum logic [1:0] {
      ANBPA_S_PRE  = 2'b00,
      ANBPA_S_HDR  = 2'b01,
      ANBPA_S_TA   = 2'b10,
      ANBPA_S_DATA = 2'b11
   } anbpa_state_t;

   // ==========================================================
   // Management frame operations
   typedef enum logic [1:0] {
      ANBPA_OP_ADDR  = 2'b00,
      ANBPA_OP_WRITE = 2'b01,
      ANBPA_OP_RDINC = 2'b10,
      ANBPA_OP_READ  = 2'b11
   } anbpa_op_t;

endpackage : anbpa_pkg

// >>> anbpa_regs.sv
// Base page advertisement registers with a serial management slave
`include "anbpa_defs.svh"

// Contract
// RULE_01: Next-page field drives D15, resets zero
// RULE_02: Acknowledge position always reads zero
// RULE_03: Remote-fault field drives D13, resets zero
// RULE_04: Pause bits drive D12:D10, reset 100
// RULE_05: Echo written value until nonces exchanged
// RULE_06: Echo field reads back last written value
// RULE_07: Selector drives D4:D0, resets 00001
// RULE_08: Mid word bits 15:8 drive D31:D24
// RULE_09: Tech bit 2 drives D23, resets one
// RULE_10: Software keeps tech bit 1 zero
// RULE_11: Tech bit 0 drives D21, resets zero
// RULE_12: Sent nonce from internal random source
// RULE_13: FEC request drives D47, resets zero
// RULE_14: FEC capability drives D46, resets one
// RULE_15: High word bits 13:0 drive D45:D32
// RULE_16: Only clause 45 frames to device seven
// RULE_17: Assemble base page at negotiation start
module anbpa_regs
   import anbpa_pkg::*;
#(
   parameter logic [4:0] PORT_ADDR = 5'h00
) (
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic        mdc_i,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe_o,
   input  wire logic        an_start_i,
   input  wire logic        base_page_ack_i,
   input  wire logic        nonce_match_i,
   input  wire logic [4:0]  lp_token_i,
   output logic [47:0]      base_page_o
);

   // ==========================================================
   // Pin synchronisers and filtered levels
   logic mdc_s1, mdc_s2, mdc_s3, mdc_lvl, next_mdc_lvl;
   logic mdio_s1, mdio_s2, mdio_s3, mdio_lvl, next_mdio_lvl;
   logic mdc_rise;
   logic din;

   // Level changes once second and third stage agree
   always_comb begin
      next_mdc_lvl  = (mdc_s2 == mdc_s3) ? mdc_s3 : mdc_lvl;
      next_mdio_lvl = (mdio_s2 == mdio_s3) ? mdio_s3 : mdio_lvl;
      mdc_rise      = next_mdc_lvl & ~mdc_lvl;
      din           = next_mdio_lvl;
   end

   // Three stage capture
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         mdc_s1   <= 1'b0;
         mdc_s2   <= 1'b0;
         mdc_s3   <= 1'b0;
         mdc_lvl  <= 1'b0;
         mdio_s1  <= 1'b1;
         mdio_s2  <= 1'b1;
         mdio_s3  <= 1'b1;
         mdio_lvl <= 1'b1;
      end else begin
         mdc_s1   <= mdc_i;
         mdc_s2   <= mdc_s1;
         mdc_s3   <= mdc_s2;
         mdc_lvl  <= next_mdc_lvl;
         mdio_s1  <= mdio_i;
         mdio_s2  <= mdio_s1;
         mdio_s3  <= mdio_s2;
         mdio_lvl <= next_mdio_lvl;
      end
   end

   // ==========================================================
   // Register storage
   logic [15:0] adv_low, adv_mid, adv_high;
   logic [15:0] next_adv_low, next_adv_mid, next_adv_high;

   // Read value of one register address
   function automatic logic [15:0] read_word(input logic [15:0] a, input logic [15:0] lo,
                                             input logic [15:0] mi, input logic [15:0] hi);
      case (a)
         `ANBPA_OFF_LOW:  read_word = lo & `ANBPA_LOW_WMASK;
         `ANBPA_OFF_MID:  read_word = mi;
         `ANBPA_OFF_HIGH: read_word = hi;
         default:         read_word = 16'h0000;
      endcase
   endfunction

   // ==========================================================
   // Serial frame engine
   anbpa_state_t state, next_state;
   logic [5:0]   cnt, next_cnt;
   logic [12:0]  hdr, next_hdr;
   logic [15:0]  wsh, next_wsh;
   logic [15:0]  rsh, next_rsh;
   logic [15:0]  addr, next_addr;
   logic         next_mdio_o, next_mdio_oe;
   logic         hit;
   logic         wr_fire;
   logic [15:0]  wr_word;
   anbpa_op_t    op;

   // Frame decode and next values
   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_hdr     = hdr;
      next_wsh     = wsh;
      next_rsh     = rsh;
      next_addr    = addr;
      next_mdio_o  = mdio_o;
      next_mdio_oe = mdio_oe_o;
      wr_fire      = 1'b0;
      wr_word      = {wsh[14:0], din};
      op           = anbpa_op_t'(hdr[11:10]);
      hit          = ~hdr[12] && (hdr[9:5] == PORT_ADDR)
                     && (hdr[4:0] == `ANBPA_DEV_AN); // RULE_16
      if (mdc_rise) begin
         case (state)
            ANBPA_S_PRE: begin
               if (din) begin
                  next_cnt = (cnt == `ANBPA_PRE_ONES) ? cnt : cnt + 6'd1;
               end else if (cnt == `ANBPA_PRE_ONES) begin
                  next_state = ANBPA_S_HDR;
                  next_cnt   = 6'd0;
               end else begin
                  next_cnt = 6'd0;
               end
            end
            ANBPA_S_HDR: begin
               next_hdr = {hdr[11:0], din};
               if (cnt == `ANBPA_HDR_LAST) begin
                  next_state = ANBPA_S_TA;
                  next_cnt   = 6'd0;
               end else begin
                  next_cnt = cnt + 6'd1;
               end
            end
            ANBPA_S_TA: begin
               if (cnt == 6'd0) begin
                  next_cnt = 6'd1;
                  if (hit && op[1]) begin
                     next_mdio_oe = 1'b1;
                     next_mdio_o  = 1'b0;
                  end
               end else begin
                  next_rsh    = read_word(addr, adv_low, adv_mid, adv_high); // RULE_02 RULE_06
                  next_mdio_o = mdio_oe_o & next_rsh[15];
                  next_state  = ANBPA_S_DATA;
                  next_cnt    = 6'd0;
               end
            end
            ANBPA_S_DATA: begin
               next_wsh    = wr_word;
               next_rsh    = {rsh[14:0], 1'b0};
               next_mdio_o = mdio_oe_o & rsh[14];
               if (cnt == `ANBPA_DATA_LAST) begin
                  next_mdio_oe = 1'b0;
                  next_mdio_o  = 1'b0;
                  next_state   = ANBPA_S_PRE;
                  next_cnt     = 6'd0;
                  if (hit) begin // RULE_16
                     case (op)
                        ANBPA_OP_ADDR:  next_addr = wr_word;
                        ANBPA_OP_WRITE: wr_fire = 1'b1;
                        ANBPA_OP_RDINC: next_addr = addr + 16'h0001;
                        default:        next_addr = addr;
                     endcase
                  end
               end else begin
                  next_cnt = cnt + 6'd1;
               end
            end
            default: begin
               next_state = ANBPA_S_PRE;
               next_cnt   = 6'd0;
            end
         endcase
      end
   end

   // Frame engine registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state     <= ANBPA_S_PRE;
         cnt       <= 6'd0;
         hdr       <= 13'h1FFF;
         wsh       <= 16'h0000;
         rsh       <= 16'h0000;
         addr      <= 16'h0000;
         mdio_o    <= 1'b0;
         mdio_oe_o <= 1'b0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         hdr       <= next_hdr;
         wsh       <= next_wsh;
         rsh       <= next_rsh;
         addr      <= next_addr;
         mdio_o    <= next_mdio_o;
         mdio_oe_o <= next_mdio_oe;
      end
   end

   // ==========================================================
   // Register writes
   always_comb begin
      next_adv_low  = adv_low;
      next_adv_mid  = adv_mid;
      next_adv_high = adv_high;
      if (wr_fire) begin
         case (addr)
            `ANBPA_OFF_LOW:  next_adv_low = wr_word & `ANBPA_LOW_WMASK; // RULE_02
            `ANBPA_OFF_MID:  next_adv_mid = wr_word;
            `ANBPA_OFF_HIGH: next_adv_high = wr_word;
            default:         next_adv_low = adv_low;
         endcase
      end
   end

   // Register storage with documented reset values
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         adv_low  <= `ANBPA_RST_LOW;
         adv_mid  <= `ANBPA_RST_MID;
         adv_high <= `ANBPA_RST_HIGH;
      end else begin
         adv_low  <= next_adv_low;
         adv_mid  <= next_adv_mid;
         adv_high <= next_adv_high;
      end
   end

   // ==========================================================
   // Random source and codeword assembly
   logic [15:0] lfsr, next_lfsr;
   logic [47:0] next_page;
   logic [4:0]  echo_tx;

   // Galois shift and page build
   always_comb begin
      next_lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `ANBPA_LFSR_TAPS : 16'h0000);
      echo_tx   = nonce_match_i ? lp_token_i
                  : adv_low[`ANBPA_ECHO_MSB:`ANBPA_ECHO_LSB]; // RULE_05
      next_page = base_page_o;
      if (an_start_i) begin
         next_page[`ANBPA_CW_HIGH_MSB:`ANBPA_CW_HIGH_LSB] = adv_high; // RULE_13 RULE_14 RULE_15
         next_page[`ANBPA_CW_MID_MSB:`ANBPA_CW_MID_LSB]
            = adv_mid[`ANBPA_MID_MSB:`ANBPA_MID_LSB]; // RULE_08 RULE_09 RULE_11
         next_page[`ANBPA_CW_TOK_MSB:`ANBPA_CW_TOK_LSB] = lfsr[4:0]; // RULE_12
         next_page[15:0] = adv_low; // RULE_01 RULE_03 RULE_04 RULE_07 RULE_17
      end
      next_page[`ANBPA_ACK_BIT] = base_page_ack_i;
      next_page[`ANBPA_ECHO_MSB:`ANBPA_ECHO_LSB] = echo_tx; // RULE_05
   end

   // Codeword registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         lfsr        <= `ANBPA_LFSR_SEED;
         base_page_o <= 48'h0000_0000_0000;
      end else begin
         lfsr        <= next_lfsr;
         base_page_o <= next_page;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_reset_values: assert property (@(posedge mclk_i) disable iff (1'b0) // RULE_01
      reset_i |=> adv_low == `ANBPA_RST_LOW && adv_mid == `ANBPA_RST_MID
                  && adv_high == `ANBPA_RST_HIGH)
      else $error("advertisement reset value wrong");
   a_ack_reads_zero: assert property ( // RULE_02
      state == ANBPA_S_TA && cnt == 6'd1 && mdc_rise |=> rsh[`ANBPA_ACK_BIT] == 1'b0
                                                          || addr != `ANBPA_OFF_LOW)
      else $error("acknowledge position read nonzero");
   a_low_on_start: assert property ( // RULE_03
      an_start_i |=> base_page_o[15] == $past(adv_low[15])
                     && base_page_o[13:10] == $past(adv_low[13:10])
                     && base_page_o[4:0] == $past(adv_low[4:0]))
      else $error("low word fields not placed in codeword");
   a_echo_written: assert property ( // RULE_05
      !nonce_match_i |=> base_page_o[9:5] == $past(adv_low[9:5]))
      else $error("written echo value not sent");
   a_echo_partner: assert property ( // RULE_05
      nonce_match_i |=> base_page_o[9:5] == $past(lp_token_i))
      else $error("partner nonce not echoed");
   a_echo_readback: assert property ( // RULE_06
      wr_fire && addr == `ANBPA_OFF_LOW ##1 !wr_fire [*2]
         |-> adv_low[9:5] == $past(wr_word[9:5], 2))
      else $error("echo field does not read back written value");
   a_mid_on_start: assert property ( // RULE_08
      an_start_i |=> base_page_o[31:21] == $past(adv_mid[15:5]))
      else $error("technology bits not placed in codeword");
   a_token_random: assert property ( // RULE_12
      an_start_i |=> base_page_o[20:16] == $past(lfsr[4:0]))
      else $error("sent nonce not from random source");
   a_high_on_start: assert property ( // RULE_15
      an_start_i ##1 !an_start_i |=> base_page_o[47:32] == $past(adv_high, 2))
      else $error("high word not placed in codeword");
   a_foreign_frame: assert property ( // RULE_16
      wr_fire |-> hit && !hdr[12] && hdr[4:0] == `ANBPA_DEV_AN)
      else $error("write from foreign frame");
   a_drive_only_hit: assert property ( // RULE_16
      $rose(mdio_oe_o) |-> state == ANBPA_S_TA && hit && op[1])
      else $error("pin driven without matching read");

endmodule : anbpa_regs

// >>> anbpa_regs_tb.sv
// Self-checking bench of the base page advertisement bank
module autoneg_base_page_advert_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import anbpa_pkg::*;

   localparam logic [4:0]  TOK  = 5'h16;
   localparam logic [47:0] MASK = 48'hFFFF_FFE0_FFFF;

   logic        mclk_i, reset_i, mdc_i, host_d, host_oe, go, ack_req, exch;
   logic        mdio_o, mdio_oe_o, an_start, ack, match;
   logic [4:0]  lp_tok;
   logic [47:0] base_page_o;
   wire         mdio_w = mdio_oe_o ? mdio_o : (host_oe ? host_d : 1'b1);
   logic [1:0]  st_bits;
   int          n_fail, checks;

   // ==========================================================
   // Design, link partner and clock
   anbpa_regs dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .mdc_i(mdc_i), .mdio_i(mdio_w),
      .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .an_start_i(an_start),
      .base_page_ack_i(ack), .nonce_match_i(match), .lp_token_i(lp_tok),
      .base_page_o(base_page_o));
   anbpa_lp_model #(.LP_TOKEN(TOK)) lp_u (.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go),
      .ack_i(ack_req), .exch_i(exch), .an_start_o(an_start), .ack_o(ack),
      .nonce_match_o(match), .lp_token_o(lp_tok));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // ==========================================================
   // Compare and closing tasks
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t word got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp48(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if ((got & MASK) !== (exp & MASK)) begin
         n_fail++;
         $display("[ERR] %0t page got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Management frame: preamble, header, turnaround, data
   task automatic frame(input anbpa_op_t op, input logic [4:0] dev, input logic [15:0] d,
                        output logic [15:0] q);
      logic [31:0] w;
      w = {st_bits, op, 5'h00, dev, 2'b10, d};
      for (int i = 0; i < 64; i++) begin
         host_d  <= (i < 32) ? 1'b1 : w[63-i];
         // Let go of the pin from the turnaround on reads
         host_oe <= !(op[1] && i >= 46);
         repeat (6) @(posedge mclk_i);
         if (i >= 48) q[63-i] = mdio_w;
         mdc_i <= 1'b1;
         repeat (6) @(posedge mclk_i);
         mdc_i <= 1'b0;
      end
      host_oe <= 1'b0;
      // Idle edge so a following frame never reassigns the enable at once
      @(posedge mclk_i);
   endtask
   task automatic wr(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] v);
      logic [15:0] q;
      frame(ANBPA_OP_ADDR, dev, a, q);
      frame(ANBPA_OP_WRITE, dev, v, q);
   endtask
   task automatic rd(input logic [4:0] dev, input logic [15:0] a, output logic [15:0] q);
      frame(ANBPA_OP_ADDR, dev, a, q);
      frame(ANBPA_OP_READ, dev, 16'h0000, q);
   endtask
   task automatic start();
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      repeat (4) @(posedge mclk_i);
   endtask
   function automatic logic [47:0] page(input logic [15:0] lo, input logic [15:0] mi,
      input logic [15:0] hi, input logic ak, input logic [4:0] echo);
      return {hi, mi[15:5], 5'h00, lo[15], ak, lo[13:10], echo, lo[4:0]};
   endfunction

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      logic [15:0] q;
      rd(5'h07, 16'h0010, q);
      cmp16(q, 16'h1001);
      rd(5'h07, 16'h0011, q);
      cmp16(q, 16'h0080);
      rd(5'h07, 16'h0012, q);
      cmp16(q, 16'h4000);
      $display("test reset done");
   endtask
   task automatic t_refuse();
      logic [15:0] q;
      wr(5'h01, 16'h0010, 16'hFFFF);
      rd(5'h07, 16'h0010, q);
      cmp16(q, 16'h1001);
      rd(5'h01, 16'h0010, q);
      cmp16(q, 16'hFFFF);
      rd(5'h07, 16'h0013, q);
      cmp16(q, 16'h0000);
      // Start code of the other addressing mode must not reach the bank
      st_bits = 2'b01;
      wr(5'h07, 16'h0010, 16'hFFFF);
      st_bits = 2'b00;
      rd(5'h07, 16'h0010, q);
      cmp16(q, 16'h1001);
      $display("test refuse done");
   endtask
   task automatic t_page();
      logic [15:0] q;
      wr(5'h07, 16'h0010, 16'hFFFF);
      rd(5'h07, 16'h0010, q);
      cmp16(q, 16'hBFFF);
      wr(5'h07, 16'h0010, 16'hA9C2);
      wr(5'h07, 16'h0011, 16'h5A35);
      wr(5'h07, 16'h0012, 16'h9ABC);
      rd(5'h07, 16'h0011, q);
      cmp16(q, 16'h5A35);
      start();
      cmp48(base_page_o, page(16'hA9C2, 16'h5A35, 16'h9ABC, 1'b0, 5'h0E));
      ack_req <= 1'b1;
      exch    <= 1'b1;
      repeat (4) @(posedge mclk_i);
      cmp48(base_page_o, page(16'hA9C2, 16'h5A35, 16'h9ABC, 1'b1, TOK));
      wr(5'h07, 16'h0010, 16'h0000);
      cmp48(base_page_o, page(16'hA9C2, 16'h5A35, 16'h9ABC, 1'b1, TOK));
      start();
      cmp48(base_page_o, page(16'h0000, 16'h5A35, 16'h9ABC, 1'b1, TOK));
      exch    <= 1'b0;
      ack_req <= 1'b0;
      repeat (4) @(posedge mclk_i);
      cmp48(base_page_o, page(16'h0000, 16'h5A35, 16'h9ABC, 1'b0, 5'h00));
      $display("test page done");
   endtask
   task automatic t_incr();
      logic [15:0] q;
      // Read with post increment walks the pointer across the bank
      frame(ANBPA_OP_ADDR, 5'h07, 16'h0011, q);
      frame(ANBPA_OP_RDINC, 5'h07, 16'h0000, q);
      cmp16(q, 16'h5A35);
      frame(ANBPA_OP_RDINC, 5'h07, 16'h0000, q);
      cmp16(q, 16'h9ABC);
      frame(ANBPA_OP_READ, 5'h07, 16'h0000, q);
      cmp16(q, 16'h0000);
      $display("test increment done");
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      n_fail  = 0;
      checks  = 0;
      reset_i = 1'b1;
      mdc_i   = 1'b0;
      host_d  = 1'b1;
      host_oe = 1'b0;
      go      = 1'b0;
      ack_req = 1'b0;
      exch    = 1'b0;
      st_bits = 2'b00;
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      t_reset();
      t_refuse();
      t_page();
      t_incr();
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge mclk_i);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end
endmodule // autoneg_base_page_advert_tb
